// file: include/tpo_pkg.sv
`default_nettype none
package tpo_pkg;

    // -------------------------------------------------------------
    // Register addresses
    // -------------------------------------------------------------
    localparam logic [31:0] ADDR_OUTPUT_CTRL = 32'hc000_0076;
    localparam logic [31:0] ADDR_TIMER_CTRL = 32'hc000_0088;
    localparam logic [31:0] ADDR_COUNT_LO = 32'hc000_008a;
    localparam logic [31:0] ADDR_COUNT_HI = 32'hc000_008b;

    // -------------------------------------------------------------
    // Second timer control fields
    // -------------------------------------------------------------
    localparam int STC_COUNT_EN_BIT = 7;
    localparam int STC_CLK_SEL_BIT = 2;
    localparam int STC_IM_SEL_HI_BIT = 1;
    localparam int STC_IM_SEL_LO_BIT = 0;
    localparam logic [7:0] STC_WRITE_MASK = 8'h87;
    localparam logic [7:0] STC_RESET = 8'h00;

    // -------------------------------------------------------------
    // Output control fields
    // -------------------------------------------------------------
    localparam int TOC_B_ENABLE_BIT = 7;
    localparam int TOC_B_LEVEL_BIT = 6;
    localparam int TOC_A_ENABLE_BIT = 5;
    localparam int TOC_A_LEVEL_BIT = 4;
    localparam int TOC_B_FUNC_BIT = 1;
    localparam int TOC_A_FUNC_BIT = 0;
    localparam logic [7:0] TOC_WRITE_MASK = 8'hf3;
    localparam logic [7:0] TOC_RESET = 8'h03;

    // -------------------------------------------------------------
    // Division ratios
    // -------------------------------------------------------------
    localparam logic [1:0] IM_SEL_DIV2 = 2'h0;
    localparam logic [1:0] IM_SEL_DIV8 = 2'h2;
    localparam int IM_DIV_LOW = 2;
    localparam int IM_DIV_HIGH = 8;
    localparam int CT_DIV_LOW = 16;
    localparam int CT_DIV_HIGH = 32;
    localparam int COUNTER_WIDTH = 16;
    localparam logic OUT_RESET_LEVEL = 1'b1;

endpackage : tpo_pkg
`default_nettype wire

// file: rtl/tpo_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tpo_prescaler (
    input wire logic clk,                   // Bus clock
    input wire logic sys_rst,               // Synchronous reset, active high
    input wire logic run,                   // Count enable; low clears the dividers
    input wire logic [1:0] im_sel,          // Intermediate clock selection
    input wire logic ct_sel,                // Count clock selection
    output logic im_tick,                   // Intermediate clock enable pulse
    output logic count_tick                 // Count clock enable pulse
);
    import tpo_pkg::*;

    // Last divider state before the intermediate pulse; reserved selections never pulse
    function automatic logic [2:0] im_limit(input logic [1:0] sel);
        if (sel == IM_SEL_DIV2) begin
            im_limit = 3'(IM_DIV_LOW - 1);
        end else if (sel == IM_SEL_DIV8) begin
            im_limit = 3'(IM_DIV_HIGH - 1);
        end else begin
            im_limit = 3'h0;
        end
    endfunction : im_limit

    function automatic logic [4:0] ct_limit(input logic sel);
        ct_limit = sel ? 5'(CT_DIV_HIGH - 1) : 5'(CT_DIV_LOW - 1);
    endfunction : ct_limit

    logic [2:0] im_cnt;
    logic [4:0] ct_cnt;
    logic [2:0] next_im_cnt;
    logic [4:0] next_ct_cnt;
    logic im_valid;

    // -------------------------------------------------------------
    // Two stage divider
    // -------------------------------------------------------------
    assign im_valid = (im_sel == IM_SEL_DIV2) || (im_sel == IM_SEL_DIV8);
    assign im_tick = run && im_valid && (im_cnt == im_limit(im_sel)); // R5 R15
    assign count_tick = im_tick && (ct_cnt == ct_limit(ct_sel)); // R4 R15

    always_comb begin
        next_im_cnt = im_cnt;
        next_ct_cnt = ct_cnt;
        if (!run || !im_valid) begin
            // Reserved selections give no pulses at all
            next_im_cnt = 3'h0;
            next_ct_cnt = 5'h00;
        end else if (im_tick) begin
            next_im_cnt = 3'h0;
            next_ct_cnt = count_tick ? 5'h00 : ct_cnt + 5'h01;
        end else begin
            next_im_cnt = im_cnt + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            im_cnt <= 3'h0;
            ct_cnt <= 5'h00;
        end else begin
            im_cnt <= next_im_cnt;
            ct_cnt <= next_ct_cnt;
        end
    end

    a_im_div8_period: assert property (@(posedge clk) disable iff (sys_rst) // R5
        (run && im_sel == IM_SEL_DIV8 && im_tick) ##1 (run && im_sel == IM_SEL_DIV8)[*8] |-> im_tick)
        else $error("intermediate pulse not every 8 cycles");

    a_im_reserved_quiet: assert property (@(posedge clk) disable iff (sys_rst) // R5
        im_sel[0] |-> !im_tick && !count_tick)
        else $error("pulse under reserved selection");

endmodule : tpo_prescaler
`default_nettype wire

// file: rtl/tpo_out_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tpo_out_ctrl (
    input wire logic clk,                   // Bus clock
    input wire logic sys_rst,               // Synchronous reset, active high
    input wire logic enable,                // Output enable bit
    input wire logic active_level,          // Active level bit
    input wire logic pin_function,          // 0 timer output, 1 interrupt input
    input wire logic coincidence,           // Compare coincidence pulse
    input wire logic pin_in,                // Pin level seen from outside
    output logic pin_out,                   // Pin drive value
    output logic pin_oe_n,                  // Pin drive enable, low drives
    output logic ext_irq                    // Synchronised interrupt input
);
    import tpo_pkg::*;

    logic level;
    logic next_level;
    logic was_enabled;
    logic sync_0;
    logic sync_1;

    // -------------------------------------------------------------
    // Output flip-flop
    // -------------------------------------------------------------
    always_comb begin
        next_level = level;
        if (!enable) begin
            next_level = !active_level; // R8 R9 R13
        end else if (!was_enabled) begin
            // Enabling edge takes the inactive level of the new active level bit
            next_level = !active_level; // R11
        end else if (coincidence) begin
            next_level = !level; // R10
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level <= OUT_RESET_LEVEL; // R16
            was_enabled <= 1'b0;
            sync_0 <= 1'b0;
            sync_1 <= 1'b0;
        end else begin
            level <= next_level;
            was_enabled <= enable;
            sync_0 <= pin_in;
            sync_1 <= sync_0;
        end
    end

    assign pin_out = level;
    assign pin_oe_n = pin_function; // R14
    assign ext_irq = pin_function ? sync_1 : 1'b0; // R14

    a_disabled_inactive: assert property (@(posedge clk) disable iff (sys_rst) // R8
        !enable |=> level == !$past(active_level))
        else $error("disabled output not at inactive level");

    a_coin_toggles: assert property (@(posedge clk) disable iff (sys_rst) // R10
        enable && was_enabled && coincidence |=> level != $past(level))
        else $error("enabled output did not change on coincidence");

    a_holds_until_coin: assert property (@(posedge clk) disable iff (sys_rst) // R11
        !enable ##1 (enable && !coincidence) |=> level == !$past(active_level))
        else $error("output left inactive level before coincidence");

    a_pin_function: assert property (@(posedge clk) disable iff (sys_rst) // R14
        pin_oe_n == pin_function && (pin_function || ext_irq == 1'b0))
        else $error("pin function routing wrong");

endmodule : tpo_out_ctrl
`default_nettype wire

// file: rtl/tpo_top.sv
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: Timer control register is 8-bit read/write.
// R2: Count enable low clears and stops counter.
// R3: Count enable high increments on count ticks.
// R4: Count select picks intermediate /16 or /32.
// R5: Intermediate field: 00 is /2, 10 is /8.
// R6: Software stops counting before changing dividers.
// R7: Output control register is 8-bit read/write.
// R8: Disabled output drives inverse of active level.
// R9: Disabled output ignores compare coincidences.
// R10: Enabled output changes on each coincidence.
// R11: Newly enabled output inactive until first coincidence.
// R12: Active bits 6 and 4, enables 7 and 5.
// R13: Active level bit 0 low, 1 high.
// R14: Pin function bit: 0 output, 1 interrupt.
// R15: Dividers are enable pulses on bus clock.
// R16: Reset gives inactive outputs, stopped cleared timer.
module tpo_top (
    input wire logic clk,                   // Bus clock, 100 MHz
    input wire logic sys_rst,               // Synchronous reset, active high
    input wire logic [31:0] reg_addr,       // Register byte address
    input wire logic [7:0] reg_wdata,       // Register write data
    input wire logic reg_wr,                // Write strobe
    input wire logic reg_rd,                // Read strobe
    output logic [7:0] reg_rdata,           // Read data, cycle after strobe
    input wire logic coincidence_a,         // Compare coincidence for output a
    input wire logic coincidence_b,         // Compare coincidence for output b
    input wire logic output_a_pin_in,       // Pin a level in
    output logic output_a_pin_out,          // Pin a drive value
    output logic output_a_pin_oe_n,         // Pin a drive enable, low drives
    input wire logic output_b_pin_in,       // Pin b level in
    output logic output_b_pin_out,          // Pin b drive value
    output logic output_b_pin_oe_n,         // Pin b drive enable, low drives
    output logic ext_irq_in_a,              // Interrupt input from pin a
    output logic ext_irq_in_b,              // Interrupt input from pin b
    output logic [15:0] second_counter_out  // Second counter value
);
    import tpo_pkg::*;

    logic [7:0] second_timer_control;
    logic [7:0] timer_output_control;
    logic [COUNTER_WIDTH-1:0] second_counter;
    logic [7:0] rdata_q;
    logic [7:0] next_stc;
    logic [7:0] next_toc;
    logic [COUNTER_WIDTH-1:0] next_counter;
    logic [7:0] next_rdata;
    logic second_count_enable;
    logic count_clock_select;
    logic [1:0] intermediate_clock_sel;
    logic count_tick;
    logic im_tick;

    // -------------------------------------------------------------
    // Field views
    // -------------------------------------------------------------
    assign second_count_enable = second_timer_control[STC_COUNT_EN_BIT];
    assign count_clock_select = second_timer_control[STC_CLK_SEL_BIT];
    assign intermediate_clock_sel = {second_timer_control[STC_IM_SEL_HI_BIT],
                                     second_timer_control[STC_IM_SEL_LO_BIT]};

    // -------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------
    always_comb begin
        next_stc = second_timer_control;
        next_toc = timer_output_control;
        if (reg_wr) begin
            if (reg_addr == ADDR_TIMER_CTRL) begin
                next_stc = reg_wdata & STC_WRITE_MASK; // R1
            end else if (reg_addr == ADDR_OUTPUT_CTRL) begin
                next_toc = reg_wdata & TOC_WRITE_MASK; // R7 R12
            end
        end
    end

    // -------------------------------------------------------------
    // Register reads
    // -------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == ADDR_TIMER_CTRL) begin
                next_rdata = second_timer_control; // R1
            end else if (reg_addr == ADDR_OUTPUT_CTRL) begin
                next_rdata = timer_output_control; // R7
            end else if (reg_addr == ADDR_COUNT_LO) begin
                next_rdata = second_counter[7:0];
            end else if (reg_addr == ADDR_COUNT_HI) begin
                next_rdata = second_counter[15:8];
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    // -------------------------------------------------------------
    // Second counter
    // -------------------------------------------------------------
    always_comb begin
        next_counter = second_counter;
        if (!second_count_enable) begin
            next_counter = '0; // R2
        end else if (count_tick) begin
            next_counter = second_counter + 16'h0001; // R3
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            second_timer_control <= STC_RESET; // R16
            timer_output_control <= TOC_RESET;
            second_counter <= '0;
            rdata_q <= 8'h00;
        end else begin
            second_timer_control <= next_stc;
            timer_output_control <= next_toc;
            second_counter <= next_counter;
            rdata_q <= next_rdata;
        end
    end

    assign reg_rdata = rdata_q;
    assign second_counter_out = second_counter;

    // -------------------------------------------------------------
    // Prescaler
    // -------------------------------------------------------------
    // Changing selections while counting may shorten one period // R6
    tpo_prescaler u_prescaler (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(second_count_enable),
        .im_sel(intermediate_clock_sel),
        .ct_sel(count_clock_select),
        .im_tick(im_tick),
        .count_tick(count_tick)
    );

    // -------------------------------------------------------------
    // Timer outputs
    // -------------------------------------------------------------
    // Enable and level bits come from the next register value, so a write that
    // enables and flips the level at once takes the inactive level of the new active level bit on that edge
    tpo_out_ctrl u_out_a (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(next_toc[TOC_A_ENABLE_BIT]),
        .active_level(next_toc[TOC_A_LEVEL_BIT]),
        .pin_function(timer_output_control[TOC_A_FUNC_BIT]),
        .coincidence(coincidence_a),
        .pin_in(output_a_pin_in),
        .pin_out(output_a_pin_out),
        .pin_oe_n(output_a_pin_oe_n),
        .ext_irq(ext_irq_in_a)
    );

    tpo_out_ctrl u_out_b (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(next_toc[TOC_B_ENABLE_BIT]),
        .active_level(next_toc[TOC_B_LEVEL_BIT]),
        .pin_function(timer_output_control[TOC_B_FUNC_BIT]),
        .coincidence(coincidence_b),
        .pin_in(output_b_pin_in),
        .pin_out(output_b_pin_out),
        .pin_oe_n(output_b_pin_oe_n),
        .ext_irq(ext_irq_in_b)
    );

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    a_stc_write_read: assert property (@(posedge clk) disable iff (sys_rst) // R1
        reg_wr && reg_addr == ADDR_TIMER_CTRL ##1 reg_rd && reg_addr == ADDR_TIMER_CTRL
        |=> reg_rdata == ($past(reg_wdata, 2) & STC_WRITE_MASK))
        else $error("timer control readback mismatch");

    a_toc_read_data: assert property (@(posedge clk) disable iff (sys_rst) // R7
        reg_rd && reg_addr == ADDR_OUTPUT_CTRL |=> reg_rdata == $past(timer_output_control))
        else $error("output control read wrong");

    a_toc_write_bits: assert property (@(posedge clk) disable iff (sys_rst) // R12
        reg_wr && reg_addr == ADDR_OUTPUT_CTRL |=> timer_output_control[3:2] == 2'h0
        && timer_output_control[7:4] == $past(reg_wdata[7:4]))
        else $error("output control fields misplaced");

    a_stopped_clear: assert property (@(posedge clk) disable iff (sys_rst) // R2
        !second_count_enable |=> second_counter == 16'h0000)
        else $error("stopped counter not cleared");

    a_count_step: assert property (@(posedge clk) disable iff (sys_rst) // R3
        second_count_enable && count_tick |=> second_counter == $past(second_counter) + 16'h0001)
        else $error("counter did not step on tick");

    a_count_hold: assert property (@(posedge clk) disable iff (sys_rst) // R15
        second_count_enable && !count_tick |=> $stable(second_counter))
        else $error("counter moved without tick");

    a_div16_rate: assert property (@(posedge clk) disable iff (sys_rst) // R4
        (count_tick && second_timer_control == 8'h80) ##1 (second_timer_control == 8'h80)[*8]
        |-> ##1 (second_timer_control == 8'h80)[*8] ##1 (second_timer_control == 8'h80)[*8]
        ##1 (second_timer_control == 8'h80)[*7] ##1 count_tick)
        else $error("count tick not every 32 cycles at /2 /16");

    a_tick_needs_im: assert property (@(posedge clk) disable iff (sys_rst) // R4
        count_tick |-> im_tick)
        else $error("count tick without intermediate tick");

    a_reset_state: assert property (@(posedge clk) // R16
        sys_rst |=> second_counter == 16'h0000 && !second_count_enable
        && output_a_pin_out == 1'b1 && output_b_pin_out == 1'b1)
        else $error("reset state wrong");

    a_no_read_no_data: assert property (@(posedge clk) disable iff (sys_rst) // R1
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");

endmodule : tpo_top
`default_nettype wire

// file: dv/tpo_pin_load.sv
`timescale 1ns/100ps
`default_nettype none
module tpo_pin_load (
    input wire logic pin_out,   // Value offered by the device
    input wire logic pin_oe_n,  // Low while the device drives the pin
    input wire logic ext_drive, // Level applied by the external source
    output logic pin_level      // Resolved wire level
);
    // ------------------------------------------------
    // Wire resolution
    // ------------------------------------------------
    // The external source only reaches the wire once the device lets go of it
    assign pin_level = pin_oe_n ? ext_drive : pin_out;
endmodule : tpo_pin_load
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import tpo_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] reg_addr = 32'h0000_0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [1:0] coin = 2'h0;
    logic [1:0] ext_drive = 2'h0;
    wire [1:0] pin_out, pin_oe_n, pin_level, ext_irq;
    logic [15:0] count;
    int failures = 0;
    int checks = 0;
    int cycles = 0;

    // ------------------------------------------------
    // Design, pin loads and clock
    // ------------------------------------------------
    tpo_top uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .coincidence_a(coin[0]), .coincidence_b(coin[1]),
        .output_a_pin_in(pin_level[0]), .output_a_pin_out(pin_out[0]), .output_a_pin_oe_n(pin_oe_n[0]),
        .output_b_pin_in(pin_level[1]), .output_b_pin_out(pin_out[1]), .output_b_pin_oe_n(pin_oe_n[1]),
        .ext_irq_in_a(ext_irq[0]), .ext_irq_in_b(ext_irq[1]), .second_counter_out(count));
    tpo_pin_load load_a (.pin_out(pin_out[0]), .pin_oe_n(pin_oe_n[0]), .ext_drive(ext_drive[0]),
        .pin_level(pin_level[0]));
    tpo_pin_load load_b (.pin_out(pin_out[1]), .pin_oe_n(pin_oe_n[1]), .ext_drive(ext_drive[1]),
        .pin_level(pin_level[1]));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic reg_write(input logic [31:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [31:0] addr, output logic [7:0] data);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask : reg_read

    // Coincidence pulse of one cycle, then settle past its sampling edge
    task automatic pulse(input int i);
        @(posedge clk);
        coin[i] <= 1'b1;
        @(posedge clk);
        coin[i] <= 1'b0;
        #1;
    endtask : pulse

    task automatic tally_and_finish();
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic test_reset_state();
        logic [7:0] d;
        #1;
        check(count, 16'h0000, "counter after reset");
        check(16'(pin_out), 16'h0003, "pins after reset");
        check(16'(pin_oe_n), 16'h0003, "pin drive after reset");
        reg_read(ADDR_TIMER_CTRL, d);
        check(16'(d), 16'h0000, "timer control reset");
        reg_read(ADDR_OUTPUT_CTRL, d);
        check(16'(d), 16'h0003, "output control reset");
    endtask : test_reset_state

    task automatic test_registers();
        logic [7:0] d;
        reg_write(ADDR_OUTPUT_CTRL, 8'hff);
        reg_read(ADDR_OUTPUT_CTRL, d);
        check(16'(d), 16'h00f3, "output control read back");
        reg_write(ADDR_OUTPUT_CTRL, 8'h03);
        reg_write(ADDR_TIMER_CTRL, 8'h7f);
        reg_read(ADDR_TIMER_CTRL, d);
        check(16'(d), 16'h0007, "timer control read back");
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ADDR_TIMER_CTRL;
        reg_wdata <= 8'h85;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(16'(reg_rdata), 16'h0085, "write then read with no gap");
        reg_write(ADDR_TIMER_CTRL, 8'h00);
        reg_write(32'hc000_0089, 8'h55);
        reg_read(32'hc000_0089, d);
        check(16'(d), 16'h0000, "unmapped read");
        reg_read(ADDR_OUTPUT_CTRL, d);
        check(16'(d), 16'h0003, "output control untouched");
    endtask : test_registers

    task automatic test_prescale();
        logic [7:0] sel, d;
        int period;
        for (int k = 0; k < 4; k++) begin
            sel = (k[0] ? 8'h04 : 8'h00) | 8'(k[1] ? IM_SEL_DIV8 : IM_SEL_DIV2);
            period = (k[1] ? IM_DIV_HIGH : IM_DIV_LOW) * (k[0] ? CT_DIV_HIGH : CT_DIV_LOW);
            reg_write(ADDR_TIMER_CTRL, sel);
            reg_write(ADDR_TIMER_CTRL, 8'h80 | sel);
            tick(period - 1);
            #1;
            check(count, 16'h0000, "counter before first tick");
            tick(1);
            #1;
            check(count, 16'h0001, "counter at first tick");
            tick(period);
            #1;
            check(count, 16'h0002, "counter at second tick");
            reg_read(ADDR_COUNT_LO, d);
            check(16'(d), 16'h0002, "counter low byte");
            reg_write(ADDR_TIMER_CTRL, sel);
            tick(1);
            #1;
            check(count, 16'h0000, "counter cleared on stop");
            tick(period);
            #1;
            check(count, 16'h0000, "counter held while stopped");
        end
        reg_write(ADDR_TIMER_CTRL, 8'h01);
        reg_write(ADDR_TIMER_CTRL, 8'h81);
        tick(300);
        #1;
        check(count, 16'h0000, "reserved selection idle");
        reg_write(ADDR_TIMER_CTRL, 8'h00);
    endtask : test_prescale

    task automatic test_outputs();
        logic [7:0] on, off;
        for (int i = 0; i < 2; i++) begin
            for (int lvl = 0; lvl < 2; lvl++) begin
                off = 8'(lvl) << (i ? TOC_B_LEVEL_BIT : TOC_A_LEVEL_BIT);
                on = off | (8'h01 << (i ? TOC_B_ENABLE_BIT : TOC_A_ENABLE_BIT));
                reg_write(ADDR_OUTPUT_CTRL, on);
                tick(2);
                #1;
                check(16'(pin_oe_n[i]), 16'h0000, "pin driven");
                check(16'(pin_level[i]), 16'(!lvl), "inactive until coincidence");
                pulse(i);
                check(16'(pin_level[i]), 16'(lvl), "active after coincidence");
                pulse(i);
                check(16'(pin_level[i]), 16'(!lvl), "toggle on coincidence");
                pulse(i);
                reg_write(ADDR_OUTPUT_CTRL, off);
                tick(2);
                #1;
                check(16'(pin_level[i]), 16'(!lvl), "disabled inactive");
                pulse(i);
                check(16'(pin_level[i]), 16'(!lvl), "disabled ignores coincidence");
            end
        end
    endtask : test_outputs

    task automatic test_pin_input();
        reg_write(ADDR_OUTPUT_CTRL, 8'h03);
        ext_drive <= 2'h3;
        tick(3);
        #1;
        check(16'(ext_irq), 16'h0003, "interrupt input high");
        @(posedge clk);
        ext_drive <= 2'h0;
        tick(3);
        #1;
        check(16'(ext_irq), 16'h0000, "interrupt input low");
        reg_write(ADDR_OUTPUT_CTRL, 8'h00);
        ext_drive <= 2'h3;
        tick(3);
        #1;
        check(16'(ext_irq), 16'h0000, "interrupt masked as output");
        check(16'(pin_level), 16'h0003, "timer outputs inactive");
    endtask : test_pin_input

    task automatic test_mid_reset();
        reg_write(ADDR_OUTPUT_CTRL, 8'h20);
        reg_write(ADDR_TIMER_CTRL, 8'h80);
        tick(40);
        pulse(0);
        check(16'(pin_out[0]), 16'h0000, "output active before reset");
        @(posedge clk);
        sys_rst <= 1'b1;
        tick(2);
        #1;
        check(count, 16'h0000, "counter after second reset");
        check(16'(pin_out), 16'h0003, "pins after second reset");
        check(16'(pin_oe_n), 16'h0003, "pin drive after second reset");
        @(posedge clk);
        sys_rst <= 1'b0;
        tick(64);
        #1;
        check(count, 16'h0000, "timer stays stopped");
    endtask : test_mid_reset

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        tick(16);
        sys_rst <= 1'b0;
        test_reset_state();
        test_registers();
        test_prescale();
        test_outputs();
        test_pin_input();
        test_mid_reset();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
